// ===== design/ftw_pkg.sv
// Package: widths, field positions, modes and register map for the wide transmit packer
package ftw_pkg;

   // ---------------------------------------------------------------
   // Word widths
   // ---------------------------------------------------------------
   localparam int FTW_TX_W = 44;
   localparam int FTW_RX_W = 64;
   localparam int FTW_NCH = 4;

   // ---------------------------------------------------------------
   // Transmit word field positions
   // ---------------------------------------------------------------
   localparam int FTW_LO_D = 0;
   localparam int FTW_LO_CTL = 8;
   localparam int FTW_LO_FEN = 9;
   localparam int FTW_LO_FVAL = 10;
   localparam int FTW_HI20_D = 11;
   localparam int FTW_HI20_CTL = 19;
   localparam int FTW_HI20_FEN = 20;
   localparam int FTW_HI20_FVAL = 21;
   localparam int FTW_HI10_D = 22;
   localparam int FTW_HI10_CTL = 30;
   localparam int FTW_HI10_FEN = 31;
   localparam int FTW_HI10_FVAL = 32;

   // ---------------------------------------------------------------
   // Width and mode encodings
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      FTW_W8 = 3'h0,
      FTW_W10 = 3'h1,
      FTW_W16_2020 = 3'h2,
      FTW_W16_810 = 3'h3,
      FTW_W20_20 = 3'h4,
      FTW_W20_10 = 3'h5
   } ftw_width_t;

   typedef enum logic [1:0] {
      FTW_M_8B10B = 2'h0,
      FTW_M_PCIE = 2'h1,
      FTW_M_RAW = 2'h2,
      FTW_M_PMA = 2'h3
   } ftw_mode_t;

   typedef enum logic [1:0] {
      FTW_CK_SHARED = 2'h0,
      FTW_CK_TXOWN = 2'h1,
      FTW_CK_RXOWN = 2'h2
   } ftw_clksel_t;

   // ---------------------------------------------------------------
   // Per-symbol transmit fields toward the PCS
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [9:0] data;
      logic ctl;
      logic fen;
      logic fval;
   } ftw_sym_t;

   typedef struct packed {
      ftw_sym_t hi;
      ftw_sym_t lo;
      logic compliance;
      logic elec_idle;
      logic idle_mismatch;
   } ftw_lane_t;

   // ---------------------------------------------------------------
   // Register map (word-aligned byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] FTW_A_CFG = 4'h0;
   localparam logic [3:0] FTW_A_CLK = 4'h4;
   localparam logic [3:0] FTW_A_STAT = 4'h8;
   localparam logic [3:0] FTW_A_ID = 4'hC;
   localparam int FTW_CFG_WID_LSB = 0;
   localparam int FTW_CFG_MODE_LSB = 4;
   localparam logic [2:0] FTW_CFG_WID_RST = 3'h0;
   localparam logic [1:0] FTW_CFG_MODE_RST = 2'h0;
   localparam logic [1:0] FTW_CLK_RST = 2'h0;
   // Arbitrary identification value
   localparam logic [31:0] FTW_ID_VAL = 32'h0000A5C3;

endpackage

// ===== design/ftw_lane.sv
// One channel: unpacks the wide transmit word into PCS symbol fields
module ftw_lane
   import ftw_pkg::*;
(
   input wire logic [FTW_TX_W-1:0] word_i,
   input wire ftw_width_t width_i,
   input wire ftw_mode_t mode_i,
   output ftw_lane_t lane_o
);

   // ---------------------------------------------------------------
   // Field extraction
   // ---------------------------------------------------------------
   function automatic ftw_sym_t byte_sym(input logic [FTW_TX_W-1:0] w, input int b,
                                         input logic use_flags);
      ftw_sym_t s;
      s = '0;
      s.data = {2'h0, w[b +: 8]};
      if (use_flags) begin
         s.ctl = w[b + FTW_LO_CTL];
         s.fen = w[b + FTW_LO_FEN];
         s.fval = w[b + FTW_LO_FVAL];
      end
      return s;
   endfunction

   logic flags;
   logic pcie;

   always_comb begin
      lane_o = '0;
      pcie = (mode_i == FTW_M_PCIE);
      flags = (mode_i == FTW_M_8B10B) || pcie;
      if (mode_i != FTW_M_PMA) begin
         case (width_i)
            FTW_W8: begin
               lane_o.lo = byte_sym(word_i, FTW_LO_D, flags);
               if (pcie) begin
                  lane_o.lo.fen = 1'b0;
                  lane_o.compliance = word_i[FTW_LO_FEN];
               end
            end
            FTW_W10: begin
               lane_o.lo.data = word_i[FTW_LO_D +: 10];
               if (pcie) begin
                  lane_o.elec_idle = word_i[FTW_LO_FVAL];
               end else begin
                  lane_o.lo.fval = word_i[FTW_LO_FVAL];
               end
            end
            FTW_W16_2020: begin
               lane_o.lo = byte_sym(word_i, FTW_LO_D, flags);
               lane_o.hi = byte_sym(word_i, FTW_HI20_D, flags);
            end
            FTW_W16_810: begin
               lane_o.lo = byte_sym(word_i, FTW_LO_D, flags);
               lane_o.hi = byte_sym(word_i, FTW_HI10_D, flags);
               if (pcie) begin
                  lane_o.lo.fen = 1'b0;
                  lane_o.hi.fen = 1'b0;
                  lane_o.lo.fval = 1'b0;
                  lane_o.hi.fval = 1'b0;
                  lane_o.compliance = word_i[FTW_LO_FEN];
                  lane_o.elec_idle = word_i[FTW_LO_FVAL] | word_i[FTW_HI10_FVAL];
                  lane_o.idle_mismatch = word_i[FTW_LO_FVAL] ^ word_i[FTW_HI10_FVAL];
               end
            end
            FTW_W20_20: begin
               lane_o.lo.data = word_i[FTW_LO_D +: 10];
               lane_o.hi.data = word_i[FTW_HI20_D +: 10];
            end
            FTW_W20_10: begin
               lane_o.lo.data = word_i[FTW_LO_D +: 10];
               lane_o.hi.data = word_i[FTW_HI10_D +: 10];
            end
            default: lane_o = '0;
         endcase
      end
   end

endmodule

// ===== design/ftw_top.sv
// Top: wide transmit packer for all channels, receive FIFO clock select, register slave
//
// Overview of operation
// - Transmit word is 44 bits per channel
// - Receive word is 64 bits per channel
// - Wide transmit word replaces narrow data port
// - 8-bit: data 7:0, control 8, value 10
// - 8-bit bit 9: force enable, PCIe compliance
// - 10-bit bit 10: value, PCIe electrical idle
// - 16-bit 16/20: bytes at 7:0, 18:11
// - 16-bit 16/20 flags at 8/19, 9/20, 10/21
// - 16-bit 8/10: bytes at 7:0, 29:22
// - 16-bit 8/10 flags at 8/30, 9/31, 10/32
// - PCIe 16-bit 8/10: bits 10, 32 both idle
// - 20-bit 20: symbols at 9:0, 20:11
// - 20-bit 10: symbols at 9:0, 31:22
// - Direct PMA mode drops all control fields
// - Shared: channel 0 transmit clock reads all
// - Transmit option: own transmit clock per channel
// - Receive option: own recovered clock per channel
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
module ftw_top
   import ftw_pkg::*;
#(
   parameter int NCH = FTW_NCH
)
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [NCH*FTW_TX_W-1:0] tx_wide_word_i,
   output logic [NCH*FTW_TX_W-1:0] tx_wide_seen_o,
   output ftw_lane_t [NCH-1:0] pcs_tx_o,
   input wire logic [NCH*FTW_RX_W-1:0] pcs_rx_word_i,
   output logic [NCH*FTW_RX_W-1:0] rx_wide_word_o,
   input wire logic [NCH-1:0] tx_clkout_i,
   input wire logic [NCH-1:0] rx_clkout_i,
   output logic [NCH-1:0] rx_fifo_rdclk_o
);

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   ftw_width_t width_ff;
   ftw_width_t nxt_width;
   ftw_mode_t mode_ff;
   ftw_mode_t nxt_mode;
   ftw_clksel_t clksel_ff;
   ftw_clksel_t nxt_clksel;
   logic ack_ff;
   logic nxt_ack;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [NCH-1:0] mismatch_ff;
   logic [NCH-1:0] nxt_mismatch;

   // ---------------------------------------------------------------
   // Transmit word, registered per channel
   // ---------------------------------------------------------------
   logic [NCH*FTW_TX_W-1:0] txw_ff;
   logic [NCH*FTW_TX_W-1:0] nxt_txw;
   ftw_lane_t [NCH-1:0] lane_c;
   ftw_lane_t [NCH-1:0] pcs_ff;
   ftw_lane_t [NCH-1:0] nxt_pcs;
   logic [NCH*FTW_RX_W-1:0] rxw_ff;
   logic [NCH*FTW_RX_W-1:0] nxt_rxw;

   for (genvar c = 0; c < NCH; c++) begin : g_lane
      ftw_lane u_lane (
         .word_i(txw_ff[c*FTW_TX_W +: FTW_TX_W]),
         .width_i(width_ff),
         .mode_i(mode_ff),
         .lane_o(lane_c[c])
      );
   end

   always_comb begin
      nxt_txw = tx_wide_word_i;
      nxt_pcs = lane_c;
      nxt_rxw = pcs_rx_word_i;
      if (mode_ff == FTW_M_PMA) begin
         nxt_rxw = '0;
         for (int c = 0; c < NCH; c++) begin
            nxt_rxw[c*FTW_RX_W +: 20] = pcs_rx_word_i[c*FTW_RX_W +: 20];
         end
      end
      for (int c = 0; c < NCH; c++) begin
         nxt_mismatch[c] = lane_c[c].idle_mismatch;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         txw_ff <= '0;
         pcs_ff <= '0;
         rxw_ff <= '0;
         mismatch_ff <= '0;
      end else begin
         txw_ff <= nxt_txw;
         pcs_ff <= nxt_pcs;
         rxw_ff <= nxt_rxw;
         mismatch_ff <= nxt_mismatch;
      end
   end

   assign tx_wide_seen_o = txw_ff;
   assign pcs_tx_o = pcs_ff;
   assign rx_wide_word_o = rxw_ff;

   // ---------------------------------------------------------------
   // Receive FIFO read clock selection
   // ---------------------------------------------------------------
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         case (clksel_ff)
            FTW_CK_SHARED: rx_fifo_rdclk_o[c] = tx_clkout_i[0];
            FTW_CK_TXOWN: rx_fifo_rdclk_o[c] = tx_clkout_i[c];
            FTW_CK_RXOWN: rx_fifo_rdclk_o[c] = rx_clkout_i[c];
            default: rx_fifo_rdclk_o[c] = tx_clkout_i[c];
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Avalon-MM slave, one wait state per access
   // ---------------------------------------------------------------
   function automatic ftw_width_t legal_width(input logic [2:0] v, input ftw_width_t old);
      ftw_width_t r;
      r = old;
      if (v <= 3'h5) begin
         r = ftw_width_t'(v);
      end
      return r;
   endfunction

   logic req;
   logic [31:0] cfg_word;

   always_comb begin
      req = avs_read_i | avs_write_i;
      nxt_ack = req & ~ack_ff;
      nxt_width = width_ff;
      nxt_mode = mode_ff;
      nxt_clksel = clksel_ff;
      nxt_rdata = rdata_ff;
      cfg_word = '0;
      cfg_word[FTW_CFG_WID_LSB +: 3] = width_ff;
      cfg_word[FTW_CFG_MODE_LSB +: 2] = mode_ff;
      if (avs_write_i && !ack_ff && avs_byteenable_i[0]) begin
         if (avs_address_i == FTW_A_CFG) begin
            nxt_width = legal_width(avs_writedata_i[FTW_CFG_WID_LSB +: 3], width_ff);
            nxt_mode = ftw_mode_t'(avs_writedata_i[FTW_CFG_MODE_LSB +: 2]);
         end else if (avs_address_i == FTW_A_CLK) begin
            if (avs_writedata_i[1:0] != 2'h3) begin
               nxt_clksel = ftw_clksel_t'(avs_writedata_i[1:0]);
            end
         end
      end
      if (avs_read_i && !ack_ff) begin
         if (avs_address_i == FTW_A_CFG) begin
            nxt_rdata = cfg_word;
         end else if (avs_address_i == FTW_A_CLK) begin
            nxt_rdata = {30'h0, clksel_ff};
         end else if (avs_address_i == FTW_A_STAT) begin
            nxt_rdata = 32'(mismatch_ff);
         end else if (avs_address_i == FTW_A_ID) begin
            nxt_rdata = FTW_ID_VAL;
         end else begin
            nxt_rdata = '0;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         width_ff <= ftw_width_t'(FTW_CFG_WID_RST);
         mode_ff <= ftw_mode_t'(FTW_CFG_MODE_RST);
         clksel_ff <= ftw_clksel_t'(FTW_CLK_RST);
         ack_ff <= 1'b0;
         rdata_ff <= '0;
      end else begin
         width_ff <= nxt_width;
         mode_ff <= nxt_mode;
         clksel_ff <= nxt_clksel;
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
      end
   end

   assign avs_waitrequest_o = req & ~ack_ff;
   assign avs_readdata_o = rdata_ff;

endmodule

// ===== sim/ftw_props_props.sv
// Checker: timing and field relations at the packer's ports
module ftw_props
   import ftw_pkg::*;
#(
   parameter int NCH = FTW_NCH
)
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   input wire logic [NCH*FTW_TX_W-1:0] tx_wide_word_i,
   input wire logic [NCH*FTW_TX_W-1:0] tx_wide_seen_o,
   input wire ftw_lane_t [NCH-1:0] pcs_tx_o,
   input wire logic [NCH*FTW_RX_W-1:0] pcs_rx_word_i,
   input wire logic [NCH*FTW_RX_W-1:0] rx_wide_word_o,
   input wire logic [NCH-1:0] tx_clkout_i,
   input wire logic [NCH-1:0] rx_clkout_i,
   input wire logic [NCH-1:0] rx_fifo_rdclk_o
);
   logic [1:0] sel_ff;
   logic [1:0] nxt_sel;
   logic req;
   // ---------------------------------------------------------------
   // Clock select mirror
   // ---------------------------------------------------------------
   assign req = avs_read_i | avs_write_i;
   always_comb begin
      nxt_sel = sel_ff;
      if (avs_write_i && avs_waitrequest_o && avs_address_i == FTW_A_CLK &&
          avs_byteenable_i[0] && avs_writedata_i[1:0] != 2'h3) begin
         nxt_sel = avs_writedata_i[1:0];
      end
      if (rst_i) begin
         nxt_sel = FTW_CLK_RST;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      sel_ff <= nxt_sel;
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_new_req;
      req && !$past(req);
   endsequence
   sequence s_one_wait;
      avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence
   a_bus_wait: assert property (s_new_req |-> s_one_wait)
      else $error("bus wait state wrong");
   a_seen_delay: assert property (
      !$past(rst_i) |-> tx_wide_seen_o == $past(tx_wide_word_i))
      else $error("seen copy wrong");
   a_rx_low: assert property (
      !$past(rst_i) |-> rx_wide_word_o[19:0] == $past(pcs_rx_word_i[19:0]))
      else $error("receive word wrong");
   a_lo_byte: assert property (pcs_tx_o[0] == '0 ||
      pcs_tx_o[0].lo.data[7:0] == $past(tx_wide_word_i[7:0], 2))
      else $error("low byte wrong");
   a_idle_mism: assert property (pcs_tx_o[0].idle_mismatch |->
      pcs_tx_o[0].elec_idle && $past(tx_wide_word_i[FTW_LO_FVAL], 2) !=
      $past(tx_wide_word_i[FTW_HI10_FVAL], 2))
      else $error("idle mismatch wrong");
   a_clk_shared: assert property (
      sel_ff == 2'h0 |-> rx_fifo_rdclk_o == {NCH{tx_clkout_i[0]}})
      else $error("shared clock wrong");
   a_clk_txown: assert property (
      sel_ff == 2'h1 |-> rx_fifo_rdclk_o == tx_clkout_i)
      else $error("tx clock wrong");
   a_clk_rxown: assert property (
      sel_ff == 2'h2 |-> rx_fifo_rdclk_o == rx_clkout_i)
      else $error("rx clock wrong");
endmodule

// ===== sim/ftw_fabric.sv
// Partner model: fabric logic packing symbol fields into the wide word
module ftw_fabric
   import ftw_pkg::*;
(
   input wire logic clk_sys_i,
   input wire ftw_width_t width_i,
   input wire ftw_mode_t mode_i,
   input wire ftw_sym_t lo_i,
   input wire ftw_sym_t hi_i,
   input wire logic brk_i,
   output logic [FTW_TX_W-1:0] word_o = 44'h0
);
   logic [FTW_TX_W-1:0] fill_ff = 44'h5A5A5A5A5A5;
   logic [FTW_TX_W-1:0] w;
   always_comb begin
      w = fill_ff;
      w[10:0] = {lo_i.fval, lo_i.fen, lo_i.ctl, lo_i.data[7:0]};
      case (width_i)
         FTW_W10: w[9:0] = lo_i.data;
         FTW_W16_2020: w[21:11] = {hi_i.fval, hi_i.fen, hi_i.ctl, hi_i.data[7:0]};
         FTW_W16_810: begin
            w[32:22] = {hi_i.fval, hi_i.fen, hi_i.ctl, hi_i.data[7:0]};
            if (mode_i == FTW_M_PCIE) begin
               w[31] = 1'b0;
               w[32] = lo_i.fval ^ brk_i;
            end
         end
         FTW_W20_20: w[20:0] = {hi_i.data, lo_i.fval, lo_i.data};
         FTW_W20_10: begin
            w[9:0] = lo_i.data;
            w[31:22] = hi_i.data;
         end
         default: ;
      endcase
   end
   always @(posedge clk_sys_i) begin
      fill_ff <= ~fill_ff;
      word_o <= w;
   end
endmodule

// ===== sim/ftw_top_test.sv
// Testbench: wide transmit packer, register slave and clock select
module ftw_top_test import ftw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NCH = FTW_NCH;
   typedef struct packed {
      ftw_width_t w;
      ftw_mode_t m;
      ftw_sym_t lo;
      ftw_sym_t hi;
      ftw_lane_t e;
   } ftw_row_t;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [NCH*FTW_TX_W-1:0] tx_wide_word_i;
   logic [NCH*FTW_TX_W-1:0] tx_wide_seen_o;
   ftw_lane_t [NCH-1:0] pcs_tx_o;
   logic [NCH*FTW_RX_W-1:0] pcs_rx_word_i = {NCH{64'hFEDCBA9876543210}};
   logic [NCH*FTW_RX_W-1:0] rx_wide_word_o;
   logic [NCH-1:0] tx_clkout_i = 4'h5;
   logic [NCH-1:0] rx_clkout_i = 4'h9;
   logic [NCH-1:0] rx_fifo_rdclk_o;
   ftw_width_t wid = FTW_W8;
   ftw_mode_t mode = FTW_M_8B10B;
   ftw_sym_t lo = '0;
   ftw_sym_t hi = '0;
   logic brk = 1'b0;
   logic [FTW_TX_W-1:0] fword;
   logic [31:0] q;
   logic [3:0] ck [4] = '{4'hF, 4'h5, 4'h9, 4'h9};
   int n_fail = 0;
   int n_tests = 0;
   ftw_row_t rows [11] = '{
      '{FTW_W8, FTW_M_8B10B, 13'h052E, 13'h0000, 29'h0002970},
      '{FTW_W8, FTW_M_PCIE, 13'h01E6, 13'h0000, 29'h0000F24},
      '{FTW_W10, FTW_M_8B10B, 13'h161F, 13'h0000, 29'h000B0C8},
      '{FTW_W10, FTW_M_PCIE, 13'h0AA9, 13'h0000, 29'h0005542},
      '{FTW_W16_2020, FTW_M_8B10B, 13'h078D, 13'h01F3, 29'h1F33C68},
      '{FTW_W16_810, FTW_M_8B10B, 13'h0092, 13'h0647, 29'h6470490},
      '{FTW_W16_810, FTW_M_PCIE, 13'h03BF, 13'h04CD, 29'h4CC1DE6},
      '{FTW_W20_20, FTW_M_8B10B, 13'h1D2F, 13'h12D0, 29'h12D0E940},
      '{FTW_W20_10, FTW_M_RAW, 13'h0E38, 13'h1708, 29'h170871C0},
      '{FTW_W16_2020, FTW_M_RAW, 13'h0557, 13'h02AF, 29'h2A82A80},
      '{FTW_W16_810, FTW_M_PMA, 13'h0557, 13'h02AF, 29'h0000000}};

   always #20 clk_sys_i = ~clk_sys_i;
   assign tx_wide_word_i = {NCH{fword}};

   ftw_fabric u_fab (.clk_sys_i, .width_i(wid), .mode_i(mode), .lo_i(lo), .hi_i(hi),
      .brk_i(brk), .word_o(fword));
   ftw_top #(.NCH(NCH)) dut (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .tx_wide_word_i, .tx_wide_seen_o, .pcs_tx_o, .pcs_rx_word_i, .rx_wide_word_o,
      .tx_clkout_i, .rx_clkout_i, .rx_fifo_rdclk_o);

   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t word got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_l(input ftw_lane_t got, input ftw_lane_t exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t lane got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (avs_waitrequest_o !== 1'b0) begin
         n_fail++;
         $display("[ERR] %0t bus timeout", $time);
      end
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic settle();
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
   endtask
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #400000;
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      bus(1'b0, FTW_A_CFG, 32'h0);
      chk_w(q, 32'h0);
      bus(1'b0, FTW_A_ID, 32'h0);
      chk_w(q, FTW_ID_VAL);
      bus(1'b0, 4'h2, 32'h0);
      chk_w(q, 32'h0);
      foreach (rows[i]) begin
         bus(1'b1, FTW_A_CFG, {26'h0, rows[i].m, 1'b0, rows[i].w});
         wid <= rows[i].w;
         mode <= rows[i].m;
         lo <= rows[i].lo;
         hi <= rows[i].hi;
         settle();
         chk_l(pcs_tx_o[0], rows[i].e);
         chk_l(pcs_tx_o[NCH-1], rows[i].e);
         @(posedge clk_sys_i);
      end
      chk_w(rx_wide_word_o[31:0], 32'h00043210);
      avs_byteenable_i <= 4'hE;
      bus(1'b1, FTW_A_CFG, 32'h0);
      avs_byteenable_i <= 4'hF;
      bus(1'b1, FTW_A_CFG, 32'h36);
      bus(1'b0, FTW_A_CFG, 32'h0);
      chk_w(q, 32'h33);
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, FTW_A_CLK, 32'(k));
         chk_w({28'h0, rx_fifo_rdclk_o}, {28'h0, ck[k]});
      end
      bus(1'b1, FTW_A_CFG, 32'h13);
      mode <= FTW_M_PCIE;
      lo <= 13'h0001;
      hi <= 13'h0000;
      brk <= 1'b1;
      settle();
      chk_l(pcs_tx_o[0], 29'h0000003);
      chk_w(rx_wide_word_o[NCH*FTW_RX_W-1 -: 32], 32'hFEDCBA98);
      @(posedge clk_sys_i);
      bus(1'b0, FTW_A_STAT, 32'h0);
      chk_w(q, 32'h0000000F);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      bus(1'b0, FTW_A_CLK, 32'h0);
      chk_w(q, 32'h0);
      stop_test();
   end
endmodule

bind ftw_top ftw_props #(.NCH(NCH)) u_props (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o, .tx_wide_word_i,
   .tx_wide_seen_o, .pcs_tx_o, .pcs_rx_word_i, .rx_wide_word_o, .tx_clkout_i, .rx_clkout_i,
   .rx_fifo_rdclk_o);
